// ==== core/sbcspi_cfg.svh ====
// Addresses, indices, field positions and reset values of the register access block
`ifndef SBCSPI_CFG_SVH
`define SBCSPI_CFG_SVH
`define SBCSPI_N_CTRL 12
`define SBCSPI_N_STAT 11
`define SBCSPI_FRAME_BITS 16
// Control register addresses
`define SBCSPI_A_MSC 7'h01
`define SBCSPI_A_HW0 7'h02
`define SBCSPI_A_WDG 7'h03
`define SBCSPI_A_BUS0 7'h04
`define SBCSPI_A_WK0 7'h06
`define SBCSPI_A_WK1 7'h07
`define SBCSPI_A_WKP 7'h08
`define SBCSPI_A_BUS2 7'h0a
`define SBCSPI_A_BUS3 7'h0b
`define SBCSPI_A_TMR 7'h0c
`define SBCSPI_A_HW1 7'h0e
`define SBCSPI_A_SYS 7'h1e
// Status register addresses
`define SBCSPI_A_SUP1 7'h40
`define SBCSPI_A_SUP0 7'h41
`define SBCSPI_A_THM 7'h42
`define SBCSPI_A_DEV 7'h43
`define SBCSPI_A_BS0 7'h44
`define SBCSPI_A_WS0 7'h46
`define SBCSPI_A_WLV 7'h48
`define SBCSPI_A_WS2 7'h49
`define SBCSPI_A_BS2 7'h4a
`define SBCSPI_A_BS3 7'h4b
`define SBCSPI_A_SWS 7'h4c
`define SBCSPI_A_CNV 7'h58
`define SBCSPI_A_FAM 7'h7e
// Control indices that hardware touches
`define SBCSPI_IX_MSC 4'h0
`define SBCSPI_IX_BUS0 4'h3
`define SBCSPI_IX_BUS2 4'h7
`define SBCSPI_IX_BUS3 4'h8
`define SBCSPI_IX_HW1 4'ha
// Field positions
`define SBCSPI_MODE_LSB 6
`define SBCSPI_SRST_BIT 6
`define SBCSPI_CAN1_LSB 0
`define SBCSPI_CAN2_LSB 3
// Mode and transceiver field codes
`define SBCSPI_MC_NORMAL 2'h0
`define SBCSPI_MC_SLEEP 2'h1
`define SBCSPI_MC_STOP 2'h2
`define SBCSPI_MC_RESTART 2'h3
`define SBCSPI_CAN_WAKE 2'h1
// Reset values
`define SBCSPI_CTRL_RST 8'h00
`define SBCSPI_STAT_RST 8'h00
`endif

// ==== core/sbcspi_pkg.sv ====
// Types shared by the register access block
package sbcspi_pkg;
  typedef logic [7:0] sbcspi_byte_t;
  typedef enum logic [2:0] {
    SBCSPI_INIT, SBCSPI_NORMAL, SBCSPI_STOP, SBCSPI_SLEEP, SBCSPI_RESTART, SBCSPI_FAILSAFE
  } sbcspi_mode_t;
  typedef struct packed {
    logic [7:0] data;
    logic access;
    logic [6:0] addr;
  } sbcspi_frame_t;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
  } sbcspi_pins_t;
endpackage

// ==== core/sbcspi_link.sv ====
// Serial frame receiver and transmitter sampled on the system clock
module sbcspi_link
  import sbcspi_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire sbcspi_pins_t pins,
  output logic sdo,
  output logic sdo_oe_n,
  // Frame side
  input wire logic [15:0] resp_word,
  output logic frame_start,
  output logic frame_end,
  output logic addr_done,
  output logic [6:0] addr_early,
  output sbcspi_frame_t rx_frame,
  output logic [4:0] clk_count,
  output logic edge_err
);
  sbcspi_pins_t s1_q, s2_q, s3_q;
  logic active_q;
  logic [15:0] rx_q;
  logic [3:0] tx_ix_q;
  logic done_q;
  wire cs_fall = s3_q.cs_n & ~s2_q.cs_n;
  wire cs_rise = ~s3_q.cs_n & s2_q.cs_n;
  wire sck_rise = active_q & ~s3_q.sck & s2_q.sck;
  wire sck_fall = active_q & s3_q.sck & ~s2_q.sck;

  // Two flops before any logic; the third only feeds edge detection
  always_ff @(posedge clk) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      rx_q <= 16'h0000;
      tx_ix_q <= 4'h0;
      clk_count <= 5'h00;
      edge_err <= 1'b0;
      done_q <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (cs_fall) begin
        active_q <= 1'b1;
        tx_ix_q <= 4'h0;
        clk_count <= 5'h00;
        edge_err <= s2_q.sck; // R22
      end
      if (cs_rise) begin
        active_q <= 1'b0;
        if (s2_q.sck) edge_err <= 1'b1; // R22
      end
      if (sck_fall) begin
        rx_q <= {s2_q.sdi, rx_q[15:1]}; // R21
        if (clk_count != 5'h1f) clk_count <= clk_count + 5'h01;
        done_q <= (clk_count == 5'h06);
      end
      if (sck_rise && tx_ix_q != 4'hf) tx_ix_q <= tx_ix_q + 4'h1; // R21
      sdo <= resp_word[tx_ix_q];
      sdo_oe_n <= ~(active_q & ~cs_rise); // R20
    end
  end

  assign frame_start = cs_fall;
  assign frame_end = cs_rise & active_q; // R20
  assign addr_done = done_q;
  assign addr_early = rx_q[15:9];
  assign rx_frame = sbcspi_frame_t'(rx_q);
endmodule // sbcspi_link

// ==== core/sbcspi_regs.sv ====
// Register access layer behind the 16-bit serial slave of the system basis device
`include "sbcspi_cfg.svh"
// Behaviour
// R1 - Frame bits six to zero hold the seven-bit register address.
// R2 - Bit seven: status read or read-and-clear; control read or write.
// R3 - Frame bits fifteen to eight carry the data byte both ways.
// R4 - Reads, writes and clears act on a whole byte per frame.
// R5 - Host clears latched status bits itself; device never clears them alone.
// R6 - Some control bits clear themselves automatically, per register.
// R7 - Frames are discarded in restart, sleep and fail-safe modes.
// R8 - Status access returns current register contents in the same frame.
// R9 - Control access returns pre-write value; new value seen next access.
// R10 - Every response carries an eight-bit status summary field.
// R11 - Summary bit is set while any bit of its registers is set.
// R12 - Summary bits map to supply, thermal, device, buses, wake, switcher.
// R13 - Wake level status is left out of the summary.
// R14 - Control address range holds readable and writable configuration.
// R15 - Status address range; bit seven set clears after returning contents.
// R16 - Wake level status shows live pin levels and ignores clears.
// R17 - Mode field follows the device mode on every mode change.
// R18 - Sleep entry turns transceiver fields set on into wake capable.
// R19 - Writes only in normal mode; status flags keep updating in stop.
// R20 - Frame opens on chip select low, executes on its rise, output released.
// R21 - Input sampled on falling clock, output shifted after rising clock.
// R22 - Clock count other than 0 or 16 discards frame and flags error.
// R23 - Unmapped addresses read zero and change nothing.
module sbcspi_regs
  import sbcspi_pkg::*;
#(
  parameter logic [7:0] FAM_PROD_ID = 8'h5a // Arbitrary identification value
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire sbcspi_pins_t pins,
  output logic sdo,
  output logic sdo_oe_n,
  // Device state
  input wire sbcspi_mode_t dev_mode,
  input wire sbcspi_byte_t [`SBCSPI_N_STAT-1:0] stat_set,
  input wire sbcspi_byte_t wake_level_pins,
  // Configuration out
  output sbcspi_byte_t [`SBCSPI_N_CTRL-1:0] ctrl_out,
  output logic soft_reset_req,
  output sbcspi_byte_t summary_out
);
  // Address decode: {hit, index}
  function automatic logic [4:0] ctrl_dec(input logic [6:0] a);
    case (a)
      `SBCSPI_A_MSC: return 5'h10;
      `SBCSPI_A_HW0: return 5'h11;
      `SBCSPI_A_WDG: return 5'h12;
      `SBCSPI_A_BUS0: return 5'h13;
      `SBCSPI_A_WK0: return 5'h14;
      `SBCSPI_A_WK1: return 5'h15;
      `SBCSPI_A_WKP: return 5'h16;
      `SBCSPI_A_BUS2: return 5'h17;
      `SBCSPI_A_BUS3: return 5'h18;
      `SBCSPI_A_TMR: return 5'h19;
      `SBCSPI_A_HW1: return 5'h1a;
      `SBCSPI_A_SYS: return 5'h1b;
      default: return 5'h00;
    endcase
  endfunction

  function automatic logic [4:0] stat_dec(input logic [6:0] a);
    case (a)
      `SBCSPI_A_SUP1: return 5'h10;
      `SBCSPI_A_SUP0: return 5'h11;
      `SBCSPI_A_THM: return 5'h12;
      `SBCSPI_A_DEV: return 5'h13;
      `SBCSPI_A_BS0: return 5'h14;
      `SBCSPI_A_WS0: return 5'h15;
      `SBCSPI_A_WS2: return 5'h16;
      `SBCSPI_A_BS2: return 5'h17;
      `SBCSPI_A_BS3: return 5'h18;
      `SBCSPI_A_SWS: return 5'h19;
      `SBCSPI_A_CNV: return 5'h1a;
      default: return 5'h00;
    endcase
  endfunction

  function automatic logic [1:0] mode_code(input sbcspi_mode_t m);
    case (m)
      SBCSPI_SLEEP: return `SBCSPI_MC_SLEEP;
      SBCSPI_STOP: return `SBCSPI_MC_STOP;
      SBCSPI_RESTART, SBCSPI_FAILSAFE: return `SBCSPI_MC_RESTART;
      default: return `SBCSPI_MC_NORMAL;
    endcase
  endfunction

  // Transceiver field set on (upper code bit) drops to wake capable
  function automatic logic [1:0] can_sleep(input logic [1:0] f);
    return f[1] ? `SBCSPI_CAN_WAKE : f;
  endfunction

  // Byte read back for an address, taken before any update of this frame
  function automatic sbcspi_byte_t read_byte(
    input logic [6:0] a,
    input sbcspi_byte_t [`SBCSPI_N_CTRL-1:0] c,
    input sbcspi_byte_t [`SBCSPI_N_STAT-1:0] s,
    input sbcspi_byte_t lvl
  );
    logic [4:0] cd;
    logic [4:0] sd;
    cd = ctrl_dec(a);
    sd = stat_dec(a);
    if (cd[4]) return c[cd[3:0]];
    if (sd[4]) return s[sd[3:0]];
    if (a == `SBCSPI_A_WLV) return lvl;
    if (a == `SBCSPI_A_FAM) return FAM_PROD_ID;
    return 8'h00;
  endfunction

  sbcspi_byte_t [`SBCSPI_N_CTRL-1:0] ctrl_q, ctrl_d;
  sbcspi_byte_t [`SBCSPI_N_STAT-1:0] stat_q, stat_d;
  sbcspi_byte_t lvl_s1_q, lvl_q;
  sbcspi_byte_t rdata_q, summary_q;
  sbcspi_mode_t mode_prev_q;
  logic err_q;

  // Link wires
  logic frame_start, frame_end, addr_done, edge_err;
  logic [6:0] addr_early;
  logic [4:0] clk_count;
  sbcspi_frame_t rx_frame;

  sbcspi_link u_link (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .resp_word({rdata_q, summary_q[7:1], summary_q[0] | err_q}), // R3 R10
    .frame_start(frame_start),
    .frame_end(frame_end),
    .addr_done(addr_done),
    .addr_early(addr_early),
    .rx_frame(rx_frame),
    .clk_count(clk_count),
    .edge_err(edge_err)
  );

  // Frame qualification at chip select rise
  wire soft_rst = ctrl_q[`SBCSPI_IX_HW1][`SBCSPI_SRST_BIT];
  wire blocked_mode = (dev_mode == SBCSPI_RESTART) || (dev_mode == SBCSPI_SLEEP) || // R7
                      (dev_mode == SBCSPI_FAILSAFE);
  wire count_bad = (clk_count != 5'h00) && (clk_count != 5'(`SBCSPI_FRAME_BITS));
  wire frame_ok = frame_end && (clk_count == 5'(`SBCSPI_FRAME_BITS)) && !edge_err &&
                  !blocked_mode;
  wire [4:0] end_cdec = ctrl_dec(rx_frame.addr); // R1
  wire [4:0] end_sdec = stat_dec(rx_frame.addr);
  wire wr_go = frame_ok && rx_frame.access && end_cdec[4] && (dev_mode == SBCSPI_NORMAL); // R2
  wire clr_go = frame_ok && rx_frame.access && end_sdec[4]; // R2 R15
  wire mode_chg = (dev_mode != mode_prev_q);
  wire sleep_entry = mode_chg && (dev_mode == SBCSPI_SLEEP);

  // Status summary grouping
  wire [7:0] summary_d = {
    |stat_q[9], |stat_q[6], |stat_q[5], |(stat_q[7] | stat_q[8]), // R12
    |stat_q[4], |stat_q[3], |stat_q[2], |(stat_q[0] | stat_q[1]) // R11 R12 R13
  };

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    // Self-clearing request bit; a fresh write keeps it for one cycle
    ctrl_d[`SBCSPI_IX_HW1][`SBCSPI_SRST_BIT] = 1'b0; // R6
    if (wr_go) ctrl_d[end_cdec[3:0]] = rx_frame.data; // R4 R9 R14 R19
    if (mode_chg) begin
      ctrl_d[`SBCSPI_IX_MSC][`SBCSPI_MODE_LSB +: 2] = mode_code(dev_mode); // R17
    end
    if (sleep_entry) begin
      ctrl_d[`SBCSPI_IX_BUS0][`SBCSPI_CAN1_LSB +: 2] =
        can_sleep(ctrl_q[`SBCSPI_IX_BUS0][`SBCSPI_CAN1_LSB +: 2]); // R18
      ctrl_d[`SBCSPI_IX_BUS2][`SBCSPI_CAN1_LSB +: 2] =
        can_sleep(ctrl_q[`SBCSPI_IX_BUS2][`SBCSPI_CAN1_LSB +: 2]); // R18
      ctrl_d[`SBCSPI_IX_BUS2][`SBCSPI_CAN2_LSB +: 2] =
        can_sleep(ctrl_q[`SBCSPI_IX_BUS2][`SBCSPI_CAN2_LSB +: 2]); // R18
      ctrl_d[`SBCSPI_IX_BUS3][`SBCSPI_CAN1_LSB +: 2] =
        can_sleep(ctrl_q[`SBCSPI_IX_BUS3][`SBCSPI_CAN1_LSB +: 2]); // R18
    end
  end

  // Status next value: new events win over a clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (clr_go) stat_d[end_sdec[3:0]] = 8'h00; // R4 R15
    for (int i = 0; i < `SBCSPI_N_STAT; i++) begin
      stat_d[i] = stat_d[i] | stat_set[i]; // R5 R19
    end
  end

  // Live wake pin levels, two flops from the pins
  always_ff @(posedge clk) begin
    lvl_s1_q <= wake_level_pins;
    lvl_q <= lvl_s1_q; // R16
  end

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      ctrl_q <= {`SBCSPI_N_CTRL{`SBCSPI_CTRL_RST}};
      stat_q <= {`SBCSPI_N_STAT{`SBCSPI_STAT_RST}};
      mode_prev_q <= SBCSPI_INIT;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mode_prev_q <= dev_mode;
    end
  end

  // Response byte latched once the address is in, before the data half goes out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      summary_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      summary_q <= summary_d; // R10
      if (frame_start) rdata_q <= 8'h00;
      else if (addr_done) rdata_q <= read_byte(addr_early, ctrl_q, stat_q, lvl_q); // R8 R9 R23
      if (frame_end) err_q <= count_bad | edge_err; // R22
    end
  end

  assign ctrl_out = ctrl_q;
  assign soft_reset_req = soft_rst;
  assign summary_out = summary_q;

  // Checks
  wire [4:0] early_cdec = ctrl_dec(addr_early);
  wire [4:0] early_sdec = stat_dec(addr_early);
  wire early_unmapped = !early_cdec[4] && !early_sdec[4] && (addr_early != `SBCSPI_A_WLV) &&
                        (addr_early != `SBCSPI_A_FAM);

  summary_match_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    ##1 (summary_q[2] == |$past(stat_q[3])) && (summary_q[4] == |$past(stat_q[7] | stat_q[8])))
    else $error("summary bit does not follow its status group");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
    addr_done && early_unmapped |=> rdata_q == 8'h00)
    else $error("unmapped address returned nonzero data");

  prewrite_read_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R9
    addr_done && early_cdec[4] |=> rdata_q == $past(ctrl_q[early_cdec[3:0]]))
    else $error("control read did not return the current value");

  blocked_write_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R7
    frame_end && blocked_mode && !mode_chg |=>
    $stable(ctrl_q) && (($past(stat_q) & ~stat_q) == '0))
    else $error("frame acted on while device mode discards frames");

  normal_only_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R19
    frame_end && (dev_mode != SBCSPI_NORMAL) && !mode_chg |=> $stable(ctrl_q))
    else $error("control register written outside normal mode");

  count_error_a: assert property (@(posedge clk) disable iff (!rst_n) // R22
    frame_end && count_bad |=> err_q && !$past(frame_ok))
    else $error("bad clock count not flagged");

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R15
    clr_go && |stat_set[end_sdec[3:0]] |=>
    stat_q[$past(end_sdec[3:0])] == $past(stat_set[end_sdec[3:0]]))
    else $error("event lost during read-and-clear");

  mode_track_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R17
    mode_chg && !wr_go |=> ctrl_q[`SBCSPI_IX_MSC][`SBCSPI_MODE_LSB +: 2] ==
    mode_code($past(dev_mode)))
    else $error("mode field did not follow the device mode");

  sleep_can_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R18
    sleep_entry && ctrl_q[`SBCSPI_IX_BUS3][1] |=>
    ctrl_q[`SBCSPI_IX_BUS3][`SBCSPI_CAN1_LSB +: 2] == `SBCSPI_CAN_WAKE)
    else $error("transceiver field not made wake capable on sleep entry");

  level_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
    addr_done && addr_early == `SBCSPI_A_WLV |=> rdata_q == $past(lvl_q))
    else $error("wake level read is not the live pin level");

  release_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
    frame_end |=> sdo_oe_n [*2])
    else $error("serial output not released after chip select rise");

  start_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
    frame_start |=> ##1 !sdo_oe_n)
    else $error("serial output not driven after chip select fall");

  zero_count_a: assert property (@(posedge clk) disable iff (!rst_n) // R22
    frame_end && (clk_count == 5'h00) && !edge_err |=> !err_q)
    else $error("clockless frame did not clear the error flag");

  write_lands_a: assert property (@(posedge clk) disable iff (!rst_n || soft_rst) // R4
    wr_go && !mode_chg |=> ctrl_q[$past(end_cdec[3:0])] == $past(rx_frame.data))
    else $error("written byte did not land in its register");
endmodule // sbcspi_regs

// ==== tb/sbcspi_host.sv ====
// Host-side serial master model driving the register access pins
module sbcspi_host
  import sbcspi_pkg::*;
(
  // Pins
  output sbcspi_pins_t pins,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0};
  // One frame of n clocks, LSB first, 48 ns link period, clock low at both select edges
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 'x;
    pins.cs_n = 1'b0;
    #48;
    for (int k = 0; k < n; k++) begin
      // Sampled just before the next rise, so a late output shift still lands
      r[k] = sdo_oe_n ? 1'bx : sdo;
      pins.sdi = w[k];
      pins.sck = 1'b1;
      #24;
      pins.sck = 1'b0;
      #24;
    end
    pins.cs_n = 1'b1;
    pins.sdi = ~pins.sdi;
    #96;
  endtask
endmodule // sbcspi_host

// ==== tb/tb_sbc_spi_register_access.sv ====
// Self-checking bench for the register access block
module tb_sbc_spi_register_access
  import sbcspi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'ha5; // Arbitrary identification value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sbcspi_pins_t pins;
  logic sdo, sdo_oe_n, soft_reset_req;
  sbcspi_mode_t dev_mode = SBCSPI_NORMAL;
  sbcspi_byte_t [10:0] stat_set = '0;
  sbcspi_byte_t wake_level_pins = 8'h00;
  sbcspi_byte_t [11:0] ctrl_out;
  sbcspi_byte_t summary_out;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] sr_cnt = 8'h00;
  logic [15:0] rsp;
  logic [7:0] v;
  logic [6:0] caddr [12] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h0a,
    7'h0b, 7'h0c, 7'h0e, 7'h1e};
  logic [6:0] saddr [11] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h49, 7'h4a,
    7'h4b, 7'h4c, 7'h58};
  sbcspi_byte_t sbit [11] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h10,
    8'h10, 8'h80, 8'h00};
  sbcspi_mode_t dm [3] = '{SBCSPI_SLEEP, SBCSPI_RESTART, SBCSPI_FAILSAFE};
  logic [1:0] mf [3] = '{2'h1, 2'h3, 2'h3};

  initial begin
    forever #2.5 clk = ~clk;
  end

  sbcspi_regs #(.FAM_PROD_ID(ID)) i_dut (.clk(clk), .rst_n(rst_n), .pins(pins), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .dev_mode(dev_mode), .stat_set(stat_set),
    .wake_level_pins(wake_level_pins), .ctrl_out(ctrl_out),
    .soft_reset_req(soft_reset_req), .summary_out(summary_out));

  sbcspi_host h (.pins(pins), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  always @(posedge clk) begin
    if (soft_reset_req === 1'b1) sr_cnt <= sr_cnt + 8'h01;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // Frames start on a falling clock edge so pin changes never meet a sampling edge
  task automatic acc(input logic [6:0] a, input logic rw, input sbcspi_byte_t d,
    input int n = 16);
    @(negedge clk);
    h.xfer({d, rw, a}, n, rsp);
  endtask

  task automatic pulse(input int i, input sbcspi_byte_t b);
    @(posedge clk);
    stat_set[i] <= b;
    @(posedge clk);
    stat_set[i] <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic mode(input sbcspi_mode_t m);
    @(posedge clk);
    dev_mode <= m;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    $display("FAIL %0t run did not finish in time", $time);
    conclude;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    acc(7'h01, 1'b0, 8'h00);
    chk16(rsp, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      v = 8'(8'h11 * (i + 1));
      acc(caddr[i], 1'b1, v);
      chk16(rsp, 16'h0000);
      acc(caddr[i], 1'b0, 8'hff);
      chk16(rsp, {v, 8'h00});
      chk8(ctrl_out[i], v);
    end
    acc(7'h05, 1'b1, 8'hff);
    acc(7'h05, 1'b0, 8'h00);
    chk16(rsp, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      pulse(i, 8'h81);
      chk8(summary_out, sbit[i]);
      acc(saddr[i], 1'b0, 8'h00);
      chk16(rsp, {8'h81, sbit[i]});
      acc(saddr[i], 1'b1, 8'h00);
      chk16(rsp, {8'h81, sbit[i]});
      acc(saddr[i], 1'b0, 8'h00);
      chk16(rsp, 16'h0000);
    end
    // Two supply registers share one summary bit
    pulse(0, 8'h01);
    pulse(1, 8'h02);
    acc(7'h40, 1'b1, 8'h00);
    chk8(summary_out, 8'h01);
    acc(7'h41, 1'b1, 8'h00);
    chk8(summary_out, 8'h00);
    // An event held across a read-and-clear survives it
    @(posedge clk);
    stat_set[3] <= 8'h10;
    acc(7'h43, 1'b1, 8'h00);
    chk16(rsp, 16'h1004);
    @(posedge clk);
    stat_set[3] <= 8'h00;
    acc(7'h43, 1'b1, 8'h00);
    chk16(rsp, 16'h1004);
    @(posedge clk);
    wake_level_pins <= 8'h3c;
    acc(7'h48, 1'b1, 8'h00);
    acc(7'h48, 1'b0, 8'h00);
    chk16(rsp, 16'h3c00);
    acc(7'h7e, 1'b0, 8'h00);
    chk16(rsp, {ID, 8'h00});
    acc(7'h1e, 1'b1, 8'h00, 8);
    chk8(ctrl_out[11], 8'hcc);
    acc(7'h1e, 1'b0, 8'h00);
    chk16(rsp, 16'hcc01);
    acc(7'h1e, 1'b0, 8'h00, 0);
    acc(7'h1e, 1'b0, 8'h00);
    chk16(rsp, 16'hcc00);
    mode(SBCSPI_STOP);
    chk8(ctrl_out[0], 8'h91);
    acc(7'h1e, 1'b1, 8'h00);
    chk8(ctrl_out[11], 8'hcc);
    pulse(2, 8'h04);
    acc(7'h42, 1'b1, 8'h00);
    chk16(rsp, 16'h0402);
    mode(SBCSPI_INIT);
    chk8(ctrl_out[0], 8'h11);
    acc(7'h1e, 1'b1, 8'h00);
    chk8(ctrl_out[11], 8'hcc);
    mode(SBCSPI_NORMAL);
    acc(7'h04, 1'b1, 8'h02);
    acc(7'h0a, 1'b1, 8'h1b);
    acc(7'h0b, 1'b1, 8'h03);
    pulse(2, 8'h04);
    for (int j = 0; j < 3; j++) begin
      mode(dm[j]);
      chk8(ctrl_out[0], {mf[j], 6'h11});
      if (j == 0) begin
        chk8(ctrl_out[3], 8'h01);
        chk8(ctrl_out[7], 8'h09);
        chk8(ctrl_out[8], 8'h01);
      end
      acc(7'h42, 1'b1, 8'h00);
      acc(7'h1e, 1'b1, 8'h00);
      chk8(summary_out, 8'h02);
      chk8(ctrl_out[11], 8'hcc);
    end
    mode(SBCSPI_NORMAL);
    acc(7'h0e, 1'b1, 8'h40);
    chk8(sr_cnt, 8'h01);
    chk8(ctrl_out[11], 8'h00);
    chk8(summary_out, 8'h00);
    conclude;
  end
endmodule // tb_sbc_spi_register_access
